// File: design/boundary_scan_tap.sv
// boundary scan test access port: controller, instruction and data registers
// Notes on behaviour
// - instruction register is 4 bits; only six defined codes are meant to be used
// - extest: boundary chain in path, held cells drive device outputs
// - bypass: single-bit passthrough register in serial path
// - idcode: load identification value, then shift it out
// - highz: bypass in path, all device output drivers high impedance
// - clamp: held cells drive outputs, bypass in path
// - sample: capture exclusive or of device inputs and outputs into cells, shift out on tdo
// - preload (no code of its own, done by update under sample or extest): shifted-in cell values held for later output-driving instructions
// - identification register is 32 bits long
// - bits 31:28 of identification hold revision number
// - bits 27:12 part code, bits 11:1 vendor code
// - bit 0 of identification always reads one
`include "scan_tap_consts.svh"
module boundary_scan_tap #(
  parameter int          CHAIN_LEN   = `CHAIN_LEN,
  parameter logic [3:0]  REV_VAL     = `ID_REV_VAL,   // arbitrary value
  parameter logic [15:0] PART_VAL    = `ID_PART_VAL,  // arbitrary value
  parameter logic [10:0] VEND_VAL    = `ID_VEND_VAL   // arbitrary value
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 tck_i,
  input  wire logic                 tms_i,
  input  wire logic                 tdi_i,
  input  wire logic                 trst_n_i,
  output logic                      tdo_o,
  output logic                      tdo_oe_n_o,
  input  wire logic [CHAIN_LEN-1:0] func_out_i,
  input  wire logic [CHAIN_LEN-1:0] func_oe_n_i,
  input  wire logic [CHAIN_LEN-1:0] pins_in_i,
  output logic      [CHAIN_LEN-1:0] pin_out_o,
  output logic      [CHAIN_LEN-1:0] pin_oe_n_o
);
  // the boundary chain cannot shift with fewer than two cells
  if (CHAIN_LEN < 2) begin : g_len_check
    $error("boundary_scan_tap needs CHAIN_LEN of at least 2");
  end

  // -------------------------------------------------------------
  // link pin synchronisation
  // -------------------------------------------------------------
  scan_tap_pkg::link_pins_type raw_pins;
  scan_tap_pkg::link_pins_type pins;
  scan_tap_pkg::edge_type      tck_edge;

  assign raw_pins = '{tck: tck_i, tms: tms_i, tdi: tdi_i, trst_n: trst_n_i};

  pin_sync u_sync (
    .clk_sys_i  (clk_sys_i),
    .sys_rst_i  (sys_rst_i),
    .pins_i     (raw_pins),
    .pins_o     (pins),
    .tck_edge_o (tck_edge)
  );

  // -------------------------------------------------------------
  // controller state
  // -------------------------------------------------------------
  scan_tap_pkg::tap_state_type state;
  scan_tap_pkg::tap_state_type next_state;

  // sixteen-state walk on each rising tck; trst wins over tms
  always_comb begin
    next_state = state;
    if (!pins.trst_n) begin
      next_state = scan_tap_pkg::tlr_st;
    end else if (tck_edge.rise) begin
      unique case (state)
        scan_tap_pkg::tlr_st:    next_state = pins.tms ? scan_tap_pkg::tlr_st
                                                      : scan_tap_pkg::rti_st;
        scan_tap_pkg::rti_st:    next_state = pins.tms ? scan_tap_pkg::sel_dr_st
                                                      : scan_tap_pkg::rti_st;
        scan_tap_pkg::sel_dr_st: next_state = pins.tms ? scan_tap_pkg::sel_ir_st
                                                      : scan_tap_pkg::cap_dr_st;
        scan_tap_pkg::cap_dr_st: next_state = pins.tms ? scan_tap_pkg::ex1_dr_st
                                                      : scan_tap_pkg::sh_dr_st;
        scan_tap_pkg::sh_dr_st:  next_state = pins.tms ? scan_tap_pkg::ex1_dr_st
                                                      : scan_tap_pkg::sh_dr_st;
        scan_tap_pkg::ex1_dr_st: next_state = pins.tms ? scan_tap_pkg::up_dr_st
                                                      : scan_tap_pkg::pa_dr_st;
        scan_tap_pkg::pa_dr_st:  next_state = pins.tms ? scan_tap_pkg::ex2_dr_st
                                                      : scan_tap_pkg::pa_dr_st;
        scan_tap_pkg::ex2_dr_st: next_state = pins.tms ? scan_tap_pkg::up_dr_st
                                                      : scan_tap_pkg::sh_dr_st;
        scan_tap_pkg::up_dr_st:  next_state = pins.tms ? scan_tap_pkg::sel_dr_st
                                                      : scan_tap_pkg::rti_st;
        scan_tap_pkg::sel_ir_st: next_state = pins.tms ? scan_tap_pkg::tlr_st
                                                      : scan_tap_pkg::cap_ir_st;
        scan_tap_pkg::cap_ir_st: next_state = pins.tms ? scan_tap_pkg::ex1_ir_st
                                                      : scan_tap_pkg::sh_ir_st;
        scan_tap_pkg::sh_ir_st:  next_state = pins.tms ? scan_tap_pkg::ex1_ir_st
                                                      : scan_tap_pkg::sh_ir_st;
        scan_tap_pkg::ex1_ir_st: next_state = pins.tms ? scan_tap_pkg::up_ir_st
                                                      : scan_tap_pkg::pa_ir_st;
        scan_tap_pkg::pa_ir_st:  next_state = pins.tms ? scan_tap_pkg::ex2_ir_st
                                                      : scan_tap_pkg::pa_ir_st;
        scan_tap_pkg::ex2_ir_st: next_state = pins.tms ? scan_tap_pkg::up_ir_st
                                                      : scan_tap_pkg::sh_ir_st;
        scan_tap_pkg::up_ir_st:  next_state = pins.tms ? scan_tap_pkg::sel_dr_st
                                                      : scan_tap_pkg::rti_st;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= scan_tap_pkg::tlr_st;
    end else begin
      state <= next_state;
    end
  end

  // capture and shift act at the tck rise that leaves the named state; update acts at the tck fall within it
  logic do_cap_dr;
  logic do_sh_dr;
  logic do_up_dr;
  logic do_cap_ir;
  logic do_sh_ir;
  logic do_up_ir;

  assign do_cap_dr = tck_edge.rise & pins.trst_n & (state == scan_tap_pkg::cap_dr_st);
  assign do_sh_dr  = tck_edge.rise & pins.trst_n & (state == scan_tap_pkg::sh_dr_st);
  assign do_up_dr  = tck_edge.fall & pins.trst_n & (state == scan_tap_pkg::up_dr_st);
  assign do_cap_ir = tck_edge.rise & pins.trst_n & (state == scan_tap_pkg::cap_ir_st);
  assign do_sh_ir  = tck_edge.rise & pins.trst_n & (state == scan_tap_pkg::sh_ir_st);
  assign do_up_ir  = tck_edge.fall & pins.trst_n & (state == scan_tap_pkg::up_ir_st);

  // -------------------------------------------------------------
  // instruction register
  // -------------------------------------------------------------
  logic [`TI_WIDTH-1:0] ir_shift;
  logic [`TI_WIDTH-1:0] test_instruction;
  logic [`TI_WIDTH-1:0] next_ir_shift;
  logic [`TI_WIDTH-1:0] next_test_instruction;

  // capture loads the mandatory 01 pattern; reserved codes act as bypass
  always_comb begin
    next_ir_shift         = ir_shift;
    next_test_instruction = test_instruction;
    if (do_cap_ir) begin
      next_ir_shift = 4'h1;
    end else if (do_sh_ir) begin
      next_ir_shift = {pins.tdi, ir_shift[`TI_WIDTH-1:1]};  // lsb first
    end
    if (state == scan_tap_pkg::tlr_st) begin
      next_test_instruction = `TI_IDCODE;
    end else if (do_up_ir) begin
      next_test_instruction = ir_shift;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ir_shift         <= '0;
      test_instruction <= `TI_IDCODE;
    end else begin
      ir_shift         <= next_ir_shift;
      test_instruction <= next_test_instruction;
    end
  end

  logic sel_chain;
  logic sel_id;
  logic drive_cells;
  logic force_hiz;

  assign sel_chain   = (test_instruction == `TI_EXTEST) |
                       (test_instruction == `TI_SAMPLE);
  assign sel_id      = (test_instruction == `TI_IDCODE);
  assign drive_cells = (test_instruction == `TI_EXTEST) |
                       (test_instruction == `TI_CLAMP);
  assign force_hiz   = (test_instruction == `TI_HIGHZ);

  // -------------------------------------------------------------
  // bypass and identification registers
  // -------------------------------------------------------------
  logic                 single_bit_passthrough;
  logic [`ID_WIDTH-1:0] part_identification;
  logic                 next_passthrough;
  logic [`ID_WIDTH-1:0] next_ident;
  logic [`ID_WIDTH-1:0] id_value;

  assign id_value[`ID_REV_MSB:`ID_REV_LSB]   = REV_VAL;
  assign id_value[`ID_PART_MSB:`ID_PART_LSB] = PART_VAL;
  assign id_value[`ID_VEND_MSB:`ID_VEND_LSB] = VEND_VAL;
  assign id_value[`ID_MARK_BIT]              = 1'b1;

  // reserved codes fall to bypass so the chain length stays defined
  always_comb begin
    next_passthrough = single_bit_passthrough;
    next_ident       = part_identification;
    if (do_cap_dr) begin
      next_passthrough = 1'b0;
      next_ident       = id_value;
    end else if (do_sh_dr) begin
      next_passthrough = pins.tdi;
      next_ident       = {pins.tdi, part_identification[`ID_WIDTH-1:1]};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      single_bit_passthrough <= 1'b0;
      part_identification    <= '0;
    end else begin
      single_bit_passthrough <= next_passthrough;
      part_identification    <= next_ident;
    end
  end

  // -------------------------------------------------------------
  // boundary cells
  // -------------------------------------------------------------
  logic                 chain_tdo;
  logic [CHAIN_LEN-1:0] held_cells;
  logic [CHAIN_LEN-1:0] pins_seen;

  // each cell samples its input exclusive-or its functional output
  assign pins_seen = pins_in_i ^ func_out_i;

  pin_scan_chain #(
    .LEN (CHAIN_LEN)
  ) u_chain (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .capture_i   (do_cap_dr & sel_chain),
    .shift_i     (do_sh_dr & sel_chain),
    .update_i    (do_up_dr & sel_chain),
    .tdi_i       (pins.tdi),
    .pins_seen_i (pins_seen),
    .tdo_o       (chain_tdo),
    .held_o      (held_cells)
  );

  // -------------------------------------------------------------
  // tdo output, changed on falling tck
  // -------------------------------------------------------------
  logic tdo_bit;
  logic tdo_drive;
  logic next_tdo;
  logic next_tdo_drive;
  logic sh_any;

  assign sh_any = (state == scan_tap_pkg::sh_dr_st) | (state == scan_tap_pkg::sh_ir_st);

  always_comb begin
    next_tdo       = tdo_bit;
    next_tdo_drive = tdo_drive;
    // test reset lets go of tdo at once, not at the next tck fall
    if (!pins.trst_n) begin
      next_tdo_drive = 1'b0;
    end else if (tck_edge.fall) begin
      next_tdo_drive = sh_any;
      if (state == scan_tap_pkg::sh_ir_st) begin
        next_tdo = ir_shift[0];
      end else if (sel_chain) begin
        next_tdo = chain_tdo;
      end else if (sel_id) begin
        next_tdo = part_identification[0];
      end else begin
        next_tdo = single_bit_passthrough;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tdo_bit   <= 1'b0;
      tdo_drive <= 1'b0;
    end else begin
      tdo_bit   <= next_tdo;
      tdo_drive <= next_tdo_drive;
    end
  end

  assign tdo_o      = tdo_bit;
  assign tdo_oe_n_o = ~tdo_drive;

  // -------------------------------------------------------------
  // device pin multiplexing
  // -------------------------------------------------------------
  logic [CHAIN_LEN-1:0] next_pin_out;
  logic [CHAIN_LEN-1:0] next_pin_oe_n;

  // functional path unless a test instruction owns the pins
  always_comb begin
    next_pin_out  = func_out_i;
    next_pin_oe_n = func_oe_n_i;
    if (force_hiz) begin
      next_pin_oe_n = '1;
    end else if (drive_cells) begin
      next_pin_out  = held_cells;
      next_pin_oe_n = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pin_out_o  <= '0;
      pin_oe_n_o <= '1;
    end else begin
      pin_out_o  <= next_pin_out;
      pin_oe_n_o <= next_pin_oe_n;
    end
  end
endmodule

// File: design/scan_tap_consts.svh
// constants for the boundary scan test access port
`ifndef SCAN_TAP_CONSTS_SVH
`define SCAN_TAP_CONSTS_SVH
`define TI_WIDTH      4
`define TI_EXTEST     4'h0
`define TI_SAMPLE     4'h1
`define TI_IDCODE     4'h2
`define TI_CLAMP      4'h3
`define TI_HIGHZ      4'h4
`define TI_BYPASS     4'hF
`define ID_WIDTH      32
`define ID_REV_MSB    31
`define ID_REV_LSB    28
`define ID_PART_MSB   27
`define ID_PART_LSB   12
`define ID_VEND_MSB   11
`define ID_VEND_LSB   1
`define ID_MARK_BIT   0
// identity values below are arbitrary, chosen for this block
`define ID_REV_VAL    4'h5
`define ID_PART_VAL   16'h1234
`define ID_VEND_VAL   11'h055
`define CHAIN_LEN     8
`define SYNC_STAGES   2
`endif

// File: design/scan_tap_pkg.sv
// types shared by the boundary scan test access port
package scan_tap_pkg;
  typedef enum logic [3:0] {
    tlr_st, rti_st, sel_dr_st, cap_dr_st, sh_dr_st, ex1_dr_st, pa_dr_st, ex2_dr_st, up_dr_st,
    sel_ir_st, cap_ir_st, sh_ir_st, ex1_ir_st, pa_ir_st, ex2_ir_st, up_ir_st
  } tap_state_type;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } link_pins_type;
  typedef struct packed {
    logic rise;
    logic fall;
  } edge_type;
endpackage

// File: design/pin_sync.sv
// two-stage synchroniser for the link pins with tck edge detection
`include "scan_tap_consts.svh"
module pin_sync (
  input  wire logic                    clk_sys_i,
  input  wire logic                    sys_rst_i,
  input  wire scan_tap_pkg::link_pins_type pins_i,
  output scan_tap_pkg::link_pins_type  pins_o,
  output scan_tap_pkg::edge_type       tck_edge_o
);
  scan_tap_pkg::link_pins_type stage1;
  scan_tap_pkg::link_pins_type stage2;
  logic                        tck_prev;
  scan_tap_pkg::link_pins_type next_stage1;
  scan_tap_pkg::link_pins_type next_stage2;
  logic                        next_tck_prev;

  // -------------------------------------------------------------
  // synchroniser chain
  // -------------------------------------------------------------
  // trst reset value is 1 (released) so a reset does not look like a tap reset pulse
  always_comb begin
    next_stage1   = pins_i;
    next_stage2   = stage1;
    next_tck_prev = stage2.tck;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      stage1   <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};
      stage2   <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};
      tck_prev <= 1'b0;
    end else begin
      stage1   <= next_stage1;
      stage2   <= next_stage2;
      tck_prev <= next_tck_prev;
    end
  end

  // edges seen only on the second stage, never on the first
  assign pins_o          = stage2;
  assign tck_edge_o.rise = stage2.tck & ~tck_prev;
  assign tck_edge_o.fall = ~stage2.tck & tck_prev;
endmodule

// File: design/pin_scan_chain.sv
// boundary cells: capture/shift stage plus held update stage
`include "scan_tap_consts.svh"
module pin_scan_chain #(
  parameter int LEN = `CHAIN_LEN
) (
  input  wire logic           clk_sys_i,
  input  wire logic           sys_rst_i,
  input  wire logic           capture_i,
  input  wire logic           shift_i,
  input  wire logic           update_i,
  input  wire logic           tdi_i,
  input  wire logic [LEN-1:0] pins_seen_i,
  output logic                tdo_o,
  output logic      [LEN-1:0] held_o
);
  // a single cell would leave the shift slice below reversed
  if (LEN < 2) begin : g_len_check
    $error("pin_scan_chain needs LEN of at least 2");
  end

  logic [LEN-1:0] shift_stage;
  logic [LEN-1:0] next_shift_stage;
  logic [LEN-1:0] next_held;

  // -------------------------------------------------------------
  // per-cell capture, shift and update
  // -------------------------------------------------------------
  always_comb begin
    next_shift_stage = shift_stage;
    next_held        = held_o;
    if (capture_i) begin
      next_shift_stage = pins_seen_i;
    end else if (shift_i) begin
      next_shift_stage = {tdi_i, shift_stage[LEN-1:1]};
    end
    // held copy keeps preload values until the next update
    if (update_i) begin
      next_held = shift_stage;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      shift_stage <= '0;
      held_o      <= '0;
    end else begin
      shift_stage <= next_shift_stage;
      held_o      <= next_held;
    end
  end

  assign tdo_o = shift_stage[0];
endmodule

// File: bench/scan_tap_properties.sv
// concurrent checks on the boundary scan port pins
module scan_tap_properties #(
  parameter int CHAIN_LEN = 8
) (
  input wire logic                 clk_sys_i,
  input wire logic                 sys_rst_i,
  input wire logic                 tck_i,
  input wire logic                 tms_i,
  input wire logic                 tdi_i,
  input wire logic                 trst_n_i,
  input wire logic                 tdo_o,
  input wire logic                 tdo_oe_n_o,
  input wire logic [CHAIN_LEN-1:0] func_out_i,
  input wire logic [CHAIN_LEN-1:0] func_oe_n_i,
  input wire logic [CHAIN_LEN-1:0] pins_in_i,
  input wire logic [CHAIN_LEN-1:0] pin_out_o,
  input wire logic [CHAIN_LEN-1:0] pin_oe_n_o
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // first sample after reset still shows the quiet reset values
  a_reset_quiet_pins: assert property ($past(sys_rst_i) |-> tdo_oe_n_o && tdo_o == 1'b0 &&
    pin_oe_n_o == '1 && pin_out_o == '0) else $error("outputs not quiet after reset");
  // a held test reset leaves the serial output undriven
  a_trst_tdo_off: assert property (!trst_n_i [*6] |-> tdo_oe_n_o)
    else $error("tdo driven during test reset");
  // serial data moves only after a falling test clock
  a_tdo_on_fall: assert property (!$stable(tdo_o) |-> !tck_i && $past(!tck_i, 2))
    else $error("tdo changed while tck high");
  a_oe_on_fall: assert property ($fell(tdo_oe_n_o) |-> !tck_i)
    else $error("tdo enabled outside tck low");
  a_oe_off_fall: assert property ($rose(tdo_oe_n_o) |-> !tck_i || !$past(trst_n_i, 3))
    else $error("tdo released outside tck low");
  // enables: functional copy, all driven, or all floating
  a_oe_mode_set: assert property (pin_oe_n_o == $past(func_oe_n_i) || pin_oe_n_o == '0 ||
    pin_oe_n_o == '1) else $error("pin enables mixed");
  // instruction updates act on tck fall; a rise into test-logic-reset moves pins within five clocks, so a steady high tck keeps pins put
  a_pins_steady_out: assert property ((tck_i && trst_n_i) [*6] ##0 $stable(func_out_i) |=>
    $stable(pin_out_o)) else $error("pin values moved with tck high");
  a_pins_steady_oe: assert property ((tck_i && trst_n_i) [*6] ##0 $stable(func_oe_n_i) |=>
    $stable(pin_oe_n_o)) else $error("pin enables moved with tck high");

  c_shift_seen: cover property ($fell(tdo_oe_n_o));
  c_drive_all: cover property (pin_oe_n_o == '0);
  c_float_all: cover property (pin_oe_n_o == '1 && func_oe_n_i != '1);
endmodule

// File: bench/tap_driver.sv
// behavioural test controller driving the serial test port
module tap_driver (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o,
  input  wire logic tdo_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // pin idle levels
  // ------------------------------------------------------------
  // tck stands low between frames
  initial begin
    tck_o    = 1'b0;
    tms_o    = 1'b1;
    tdi_o    = 1'b0;
    trst_n_o = 1'b1;
  end

  // one 125 ns tck period; tdo read just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms_o <= m;
    tdi_o <= d;
    #62.5;
    q = tdo_i;
    tck_o <= 1'b1;
    #62.5;
    tck_o <= 1'b0;
  endtask

  // from run-test-idle through a data or instruction scan back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] q);
    logic b;
    q = '0;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      q[i] = b;
    end
    // tdi turned over so a stale bit cannot look valid
    step(1'b1, ~din[n-1], b);
    step(1'b0, din[n-1], b);
  endtask

  // test reset held well past the sync depth
  task automatic trst_pulse();
    trst_n_o <= 1'b0;
    #80;
    trst_n_o <= 1'b1;
    #80;
  endtask
endmodule

// File: bench/boundary_scan_tap_tb_top.sv
// self-checking bench for the boundary scan test access port
`include "scan_tap_consts.svh"
module boundary_scan_tap_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  localparam logic [3:0]  REV  = 4'h6;     // arbitrary value
  localparam logic [15:0] PART = 16'hC35A; // arbitrary value
  localparam logic [10:0] VEND = 11'h2A6;  // arbitrary value
  localparam logic [31:0] ID   = {REV, PART, VEND, 1'b1};
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        tck, tms, tdi, trst_n, tdo, tdo_oe_n;
  logic [7:0]  fo  = 8'h3C;
  logic [7:0]  foe = 8'h5A;
  logic [7:0]  pin = 8'h00;
  logic [7:0]  po, poe;
  logic [31:0] q;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  boundary_scan_tap #(.CHAIN_LEN(8), .REV_VAL(REV), .PART_VAL(PART), .VEND_VAL(VEND)) dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .func_out_i(fo),
    .func_oe_n_i(foe), .pins_in_i(pin), .pin_out_o(po), .pin_oe_n_o(poe));
  tap_driver u_ctrl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic drive(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge clk_sys_i);
    fo  <= a;
    foe <= b;
    pin <= c;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask

  // instruction scan; capture pattern comes back first
  task automatic load_ir(input logic [3:0] code);
    u_ctrl.scan(1'b1, 4, {28'h0, code}, q);
    chk(q, 32'h1);
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask

  // one-bit path: captured zero, then tdi delayed by one
  task automatic bypass_chk();
    u_ctrl.scan(1'b0, 4, 32'hD, q);
    chk(q, 32'hA);
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    @(posedge clk_sys_i);
    #1;
    chk(poe, 32'hFF);
    chk(tdo_oe_n, 32'h1);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    drive(8'h3C, 8'h5A, 8'h00);
    chk(po, 32'h3C);
    chk(poe, 32'h5A);
    $display("test reset done");

    u_ctrl.step(1'b0, 1'b0, q[0]);
    u_ctrl.scan(1'b0, 32, 32'h0, q);
    chk(q, ID);
    chk(q[31:28], REV);
    chk(q[27:12], PART);
    chk(q[11:1], VEND);
    chk(q[0], 32'h1);
    $display("test idcode done");

    load_ir(`TI_BYPASS);
    bypass_chk();
    load_ir(`TI_CLAMP);
    bypass_chk();
    $display("test bypass done");

    load_ir(`TI_HIGHZ);
    chk(poe, 32'hFF);
    bypass_chk();
    $display("test highz done");

    drive(8'hA5, 8'h5A, 8'h96);
    load_ir(`TI_SAMPLE);
    u_ctrl.scan(1'b0, 8, 32'hC3, q);
    chk(q, 32'h33);
    load_ir(`TI_EXTEST);
    chk(po, 32'hC3);
    chk(poe, 32'h00);
    $display("test sample extest done");

    drive(8'h0F, 8'hF0, 8'h96);
    load_ir(`TI_CLAMP);
    chk(po, 32'hC3);
    chk(poe, 32'h00);
    bypass_chk();
    $display("test clamp done");

    // enter shift-dr so tdo is driven, then test reset must release it
    u_ctrl.step(1'b1, 1'b0, q[0]);
    u_ctrl.step(1'b0, 1'b0, q[0]);
    u_ctrl.step(1'b0, 1'b0, q[0]);
    repeat (6) @(posedge clk_sys_i);
    #1;
    chk(tdo_oe_n, 32'h0);
    u_ctrl.trst_pulse();
    chk(tdo_oe_n, 32'h1);
    drive(8'h0F, 8'hF0, 8'h96);
    chk(po, 32'h0F);
    chk(poe, 32'hF0);
    u_ctrl.step(1'b0, 1'b0, q[0]);
    u_ctrl.scan(1'b0, 32, 32'h0, q);
    chk(q, ID);
    $display("test trst done");
    print_verdict();
  end

  // watchdog well beyond the expected run of about 24 us
  initial begin
    #300000;
    n_fail++;
    print_verdict();
  end
endmodule

bind boundary_scan_tap scan_tap_properties #(.CHAIN_LEN(CHAIN_LEN)) u_props (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
  .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o), .func_out_i(func_out_i),
  .func_oe_n_i(func_oe_n_i), .pins_in_i(pins_in_i), .pin_out_o(pin_out_o),
  .pin_oe_n_o(pin_oe_n_o));
